/* ssc_pkg.sv */
// What this block does
// - clock codes 000-110 internal, 111 external
// - bit order: 0 lsb first, 1 msb first
// - start writes 1 begin; 0 requests reserved stop
// - mode 00 stop, 01 tx, 10 rx, 11 both
// - edge, clock, order locked while transfer active
// - only mode 00 accepted while transfer active
// - start stays 0 when mode is 00
// - slow modes run only with clock code 110
// - deep power modes force mode and start 0
// - status bit 7 shows transfer active
// - status bit 6 shows shifting in progress
// - status bit 5 sticky receive overrun
// - status bit 3 sticky transmit underrun
// - status read clears overrun and underrun
// - status bit 4 receive done, cleared by data read
// - status bit 2 transmit buffer holds data
// - mode 00 write clears all status bits
// - status bits 1-0 read 0; all reset 0
// - clock gate bit 0 makes block unusable
// - edge bit picks drive and sample edges
// - start sets active, shifting, raises request
package ssc_pkg;
    localparam logic [15:0] OFS_CONTROL  = 16'h001f;
    localparam logic [15:0] OFS_STATUS   = 16'h0020;
    localparam logic [15:0] OFS_DATA     = 16'h0021;
    localparam logic [15:0] OFS_PWR_GATE = 16'h0f76;
    localparam int CTL_EDG    = 7;
    localparam int CTL_CKS_HI = 6;
    localparam int CTL_CKS_LO = 4;
    localparam int CTL_DIR    = 3;
    localparam int CTL_START  = 2;
    localparam int CTL_MODE_HI = 1;
    localparam int PWR_GATE_BIT = 0;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] TXBUF_RST   = 8'hff;
    localparam logic [7:0] RXBUF_RST   = 8'h00;
    localparam logic [2:0] CKS_SLOW_OK = 3'h6;
    localparam logic [2:0] CKS_EXT     = 3'h7;
    localparam logic [2:0] LAST_BIT    = 3'h7;
    localparam logic [1:0] LF_DIV_LAST = 2'h3;
    typedef enum logic [1:0] {
        MODE_STOP = 2'b00,
        MODE_TX   = 2'b01,
        MODE_RX   = 2'b10,
        MODE_TXRX = 2'b11
    } ssc_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_WAIT  = 2'b10
    } ssc_state_t;
    // half period of the internal serial clock, minus one, in gear clocks
    function automatic logic [8:0] ssc_half_cnt(input logic [2:0] cks);
        unique case (cks)
            3'h0: ssc_half_cnt = 9'h0ff;
            3'h1: ssc_half_cnt = 9'h01f;
            3'h2: ssc_half_cnt = 9'h00f;
            3'h3: ssc_half_cnt = 9'h007;
            3'h4: ssc_half_cnt = 9'h003;
            3'h5: ssc_half_cnt = 9'h001;
            default: ssc_half_cnt = 9'h000;
        endcase
    endfunction
    // slow modes only allow code 110
    function automatic logic ssc_clk_ok(input logic slow, input logic [2:0] cks);
        ssc_clk_ok = !slow || (cks == CKS_SLOW_OK);
    endfunction
endpackage

/* ssc_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_sync3 (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // pin side
    input  wire logic pin_in,
    // core side
    output logic      level_r,
    output logic      rise,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            level_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            level_r <= s3_r;
        end
    end

    assign rise = (s2_r == s3_r) && s3_r && !level_r;
    assign fall = (s2_r == s3_r) && !s3_r && level_r;
endmodule
`default_nettype wire

/* ssc_ctrl.sv */
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl
    import ssc_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    // power modes
    input  wire logic              pm_deep_enter,
    input  wire logic              pm_slow,
    input  wire logic              low_frequency_clock,
    // serial pins
    input  wire logic              serial_clock_pin_i,
    output logic                   serial_clock_pin_o,
    output logic                   serial_clock_pin_oe_n,
    input  wire logic              serial_in_pin,
    output logic                   serial_out_pin,
    // request
    output logic                   serial_irq
);
    if (ADDR_W < 12) begin : g_addr_chk
        $error("ssc_ctrl: ADDR_W too small for the register map");
    end

    logic       edg_r;
    logic [2:0] cks_r;
    logic       dir_r;
    logic       start_r;
    ssc_mode_t  mode_r;
    logic       gate_en_r;
    ssc_state_t state_r;
    logic       stop_r;
    logic [7:0] shreg_r;
    logic [2:0] bitcnt_r;
    logic [7:0] txbuf_r;
    logic [7:0] rxbuf_r;
    logic       tx_buffer_full_flag_r;
    logic       rx_done_flag_r;
    logic       rx_overrun_flag_r;
    logic       tx_underrun_flag_r;
    logic       sclk_r;
    logic [8:0] div_r;
    logic [1:0] lf_cnt_r;
    logic       so_r;
    logic       irq_r;
    logic [7:0] rdata_r;

    logic       sclk_lvl;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       si_lvl;
    logic       lf_rise;

    ssc_sync3 u_sync_sclk (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (serial_clock_pin_i),
        .level_r  (sclk_lvl),
        .rise     (sclk_rise),
        .fall     (sclk_fall)
    );

    ssc_sync3 u_sync_si (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (serial_in_pin),
        .level_r  (si_lvl),
        .rise     (),
        .fall     ()
    );

    ssc_sync3 u_sync_lf (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .pin_in   (low_frequency_clock),
        .level_r  (),
        .rise     (lf_rise),
        .fall     ()
    );

    // register decode
    logic       wr_ctl;
    logic       wr_buf;
    logic       wr_pwr;
    logic       rd_stat;
    logic       rd_buf;
    ssc_mode_t  w_mode;
    logic       active;
    logic       shifting;
    logic       ext_clk;
    logic       run_ok;
    logic       tx_on;
    logic       rx_on;

    // writes other than the gate register are dead while the gate is off
    assign wr_ctl   = reg_wr && gate_en_r && (reg_addr == ADDR_W'(OFS_CONTROL));
    assign wr_buf   = reg_wr && gate_en_r && (reg_addr == ADDR_W'(OFS_DATA));
    assign wr_pwr   = reg_wr && (reg_addr == ADDR_W'(OFS_PWR_GATE));
    assign rd_stat  = reg_rd && (reg_addr == ADDR_W'(OFS_STATUS));
    assign rd_buf   = reg_rd && (reg_addr == ADDR_W'(OFS_DATA));
    assign w_mode   = ssc_mode_t'(reg_wdata[CTL_MODE_HI:0]);
    assign active   = (state_r != ST_IDLE);
    assign shifting = (state_r == ST_SHIFT);
    assign ext_clk  = (cks_r == CKS_EXT);
    assign run_ok   = gate_en_r && ssc_clk_ok(pm_slow, cks_r);
    assign tx_on    = mode_r[0];
    assign rx_on    = mode_r[1];

    // control events
    logic start_evt;
    logic forced;
    logic stop_req;

    assign start_evt = wr_ctl && !pm_deep_enter && !active && reg_wdata[CTL_START]
                       && (w_mode != MODE_STOP)
                       && ssc_clk_ok(pm_slow, reg_wdata[CTL_CKS_HI:CTL_CKS_LO]);
    assign forced    = pm_deep_enter || (wr_ctl && (w_mode == MODE_STOP));
    assign stop_req  = wr_ctl && active && !reg_wdata[CTL_START] && (w_mode != MODE_STOP);

    // serial clock edges
    logic tick;
    logic drive_e;
    logic sample_e;

    assign tick     = shifting && run_ok && !ext_clk
                      && (pm_slow ? (lf_rise && lf_cnt_r == LF_DIV_LAST)
                                  : (div_r == ssc_half_cnt(cks_r)));
    // leaving the idle level is always the drive edge
    assign drive_e  = shifting && run_ok && (ext_clk ? (edg_r ? sclk_rise : sclk_fall)
                                                    : (tick && sclk_r == !edg_r));
    assign sample_e = shifting && run_ok && (ext_clk ? (edg_r ? sclk_fall : sclk_rise)
                                                    : (tick && sclk_r == edg_r));

    logic [7:0] shift_nxt;
    logic       byte_end;
    logic       stopping;
    logic       reload;
    logic [7:0] load_val;
    logic       underrun;
    logic       rx_done;

    assign shift_nxt = dir_r ? {shreg_r[6:0], si_lvl} : {si_lvl, shreg_r[7:1]};
    assign byte_end  = sample_e && (bitcnt_r == LAST_BIT);
    assign stopping  = stop_r || stop_req;
    assign reload    = (byte_end && tx_on && tx_buffer_full_flag_r && !stopping)
                       || (state_r == ST_WAIT && (wr_buf || tx_buffer_full_flag_r) && !stop_req);
    assign load_val  = (state_r == ST_WAIT && wr_buf) ? reg_wdata : txbuf_r;
    // with an external clock the partner keeps clocking, so no wait is possible
    assign underrun  = byte_end && tx_on && !tx_buffer_full_flag_r && !stopping && ext_clk;
    assign rx_done   = byte_end && rx_on;

    // control register
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            {edg_r, cks_r, dir_r, start_r} <= CONTROL_RST[7:2];
            mode_r <= MODE_STOP;
        end else if (pm_deep_enter) begin
            mode_r  <= MODE_STOP;
            start_r <= 1'b0;
        end else if (wr_ctl && !active) begin
            edg_r   <= reg_wdata[CTL_EDG];
            cks_r   <= reg_wdata[CTL_CKS_HI:CTL_CKS_LO];
            dir_r   <= reg_wdata[CTL_DIR];
            mode_r  <= w_mode;
            start_r <= start_evt;
        end else if (wr_ctl) begin
            if (w_mode == MODE_STOP) begin
                mode_r  <= MODE_STOP;
                start_r <= 1'b0;
            end else begin
                start_r <= reg_wdata[CTL_START];
            end
        end
    end

    // clock gate
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            gate_en_r <= 1'b0;
        end else if (wr_pwr) begin
            gate_en_r <= reg_wdata[PWR_GATE_BIT];
        end
    end

    // transfer sequencer
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
        end else if (forced) begin
            state_r <= ST_IDLE;
        end else if (start_evt) begin
            state_r <= ST_SHIFT;
        end else begin
            unique case (state_r)
                ST_IDLE: state_r <= ST_IDLE;
                ST_SHIFT: begin
                    if (byte_end && stopping) begin
                        state_r <= ST_IDLE;
                    end else if (byte_end && tx_on && !tx_buffer_full_flag_r && !ext_clk) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (stop_req) begin
                        state_r <= ST_IDLE;
                    end else if (reload) begin
                        state_r <= ST_SHIFT;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || state_r == ST_IDLE) begin
            stop_r <= 1'b0;
        end else if (stop_req) begin
            stop_r <= 1'b1;
        end
    end

    // shift register and bit count
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shreg_r  <= RXBUF_RST;
            bitcnt_r <= '0;
        end else if (start_evt || reload) begin
            shreg_r  <= start_evt ? txbuf_r : load_val;
            bitcnt_r <= '0;
        end else if (sample_e) begin
            shreg_r  <= shift_nxt;
            bitcnt_r <= bitcnt_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !shifting) begin
            so_r <= 1'b1;
        end else if (drive_e) begin
            so_r <= dir_r ? shreg_r[7] : shreg_r[0];
        end
    end

    // internal serial clock
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sclk_r <= 1'b1;
        end else if (!shifting) begin
            sclk_r <= !edg_r;
        end else if (tick) begin
            sclk_r <= !sclk_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || !shifting || tick) begin
            div_r <= '0;
        end else if (run_ok && !pm_slow) begin
            div_r <= div_r + 9'h001;
        end
    end

    // slow clock is the low-frequency clock over eight
    always_ff @(posedge core_clk) begin
        if (sys_rst || !shifting) begin
            lf_cnt_r <= '0;
        end else if (lf_rise && pm_slow) begin
            lf_cnt_r <= lf_cnt_r + 2'h1;
        end
    end

    // data buffers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            txbuf_r <= TXBUF_RST;
        end else if (wr_buf) begin
            txbuf_r <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rxbuf_r <= RXBUF_RST;
        end else if (rx_done) begin
            rxbuf_r <= shift_nxt;
        end
    end

    // status flags
    always_ff @(posedge core_clk) begin
        if (sys_rst || forced) begin
            tx_buffer_full_flag_r <= 1'b0;
        end else if (wr_buf && state_r != ST_WAIT) begin
            tx_buffer_full_flag_r <= 1'b1;
        end else if (start_evt || reload) begin
            tx_buffer_full_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || forced) begin
            rx_done_flag_r <= 1'b0;
        end else if (rx_done) begin
            rx_done_flag_r <= 1'b1;
        end else if (rd_buf) begin
            rx_done_flag_r <= 1'b0;
        end
    end

    // a new error in the reading cycle survives the read
    always_ff @(posedge core_clk) begin
        if (sys_rst || forced) begin
            rx_overrun_flag_r <= 1'b0;
        end else if (rx_done && rx_done_flag_r && !rd_buf) begin
            rx_overrun_flag_r <= 1'b1;
        end else if (rd_stat) begin
            rx_overrun_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || forced) begin
            tx_underrun_flag_r <= 1'b0;
        end else if (underrun) begin
            tx_underrun_flag_r <= 1'b1;
        end else if (rd_stat) begin
            tx_underrun_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= !forced && (start_evt || reload || (byte_end && !tx_on && !stopping));
        end
    end

    // read port
    logic [7:0] status;
    assign status = {active, shifting, rx_overrun_flag_r, rx_done_flag_r, tx_underrun_flag_r, tx_buffer_full_flag_r, 2'b00};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == ADDR_W'(OFS_CONTROL)) begin
                rdata_r <= {edg_r, cks_r, dir_r, start_r, mode_r};
            end else if (rd_stat) begin
                rdata_r <= status;
            end else if (rd_buf) begin
                rdata_r <= rxbuf_r;
            end else if (wr_pwr || reg_addr == ADDR_W'(OFS_PWR_GATE)) begin
                rdata_r <= {7'h00, gate_en_r};
            end else begin
                rdata_r <= 8'h00;
            end
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign reg_rdata             = rdata_r;
    assign serial_irq            = irq_r;
    assign serial_out_pin        = so_r;
    assign serial_clock_pin_o    = sclk_r;
    assign serial_clock_pin_oe_n = !(gate_en_r && !ext_clk);

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_start_req;
        wr_ctl && !active && reg_wdata[CTL_START] && (w_mode != MODE_STOP)
        && !pm_deep_enter && ssc_clk_ok(pm_slow, reg_wdata[CTL_CKS_HI:CTL_CKS_LO]);
    endsequence

    // flags and request come from the same edge; the request lasts one cycle
    sequence s_flags_up;
        active && shifting && start_r && serial_irq ##1 !serial_irq;
    endsequence

    AST_START_SETS_FLAGS: assert property (s_start_req |=> s_flags_up)
        else $error("start did not raise active, shifting and request");
    AST_START_NEEDS_MODE: assert property (wr_ctl && !active && w_mode == MODE_STOP
        |=> !start_r && !active)
        else $error("start taken with mode 00");
    AST_LOCKED_FIELDS: assert property (wr_ctl && active
        |=> $stable(edg_r) && $stable(cks_r) && $stable(dir_r))
        else $error("clock settings changed during transfer");
    AST_MODE_LOCK: assert property (wr_ctl && active && w_mode != MODE_STOP
        && !pm_deep_enter |=> $stable(mode_r))
        else $error("mode changed during transfer");
    AST_FORCED_CLEAR: assert property (wr_ctl && w_mode == MODE_STOP
        |=> status == 8'h00 && !active)
        else $error("mode 00 write left status bits set");
    AST_DEEP_STOP: assert property (pm_deep_enter
        |=> mode_r == MODE_STOP && !start_r && !active && $stable(cks_r))
        else $error("deep power mode did not halt the interface");
    AST_RD_CLEARS_ERR: assert property (rd_stat && !forced && !underrun && !rx_done
        |=> !rx_overrun_flag_r && !tx_underrun_flag_r && reg_rdata[1:0] == 2'b00)
        else $error("status read did not clear error flags");
    AST_SLOW_HALT: assert property (pm_slow && cks_r != CKS_SLOW_OK
        |-> !drive_e && !sample_e && !tick)
        else $error("interface ran in slow mode with wrong clock code");
    AST_RESERVED_STOP: assert property (shifting && stop_r && !forced && !start_evt
        && !byte_end |=> active)
        else $error("reserved stop ended before the byte");
    AST_BYTE_RX: assert property (rx_done && !forced |=> rx_done_flag_r && rxbuf_r == $past(shift_nxt))
        else $error("received byte not stored");
    AST_GATE_OFF: assert property (!gate_en_r && !active |=> !active)
        else $error("transfer started with the clock gate off");
endmodule
`default_nettype wire

/* ssc_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_peer (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // serial lines
    input  wire logic       sclk,
    input  wire logic       data_in,
    output logic            data_out,
    // setup from the bench
    input  wire logic       edge_sel,
    input  wire logic       msb_first,
    input  wire logic       sel,
    input  wire logic [7:0] tx_byte,
    // results
    output logic [7:0]      rx_byte,
    output logic [7:0]      done_cnt
);
    logic       sclk_q;
    logic [2:0] di;
    logic [2:0] si;
    logic       chg;
    assign chg = sel && (sclk != sclk_q);
    always_ff @(posedge core_clk) begin
        sclk_q <= sclk;
        if (sys_rst) begin
            data_out <= 1'b1;
            rx_byte  <= 8'h00;
            done_cnt <= 8'h00;
            di       <= 3'h0;
            si       <= 3'h0;
        end else if (!sel) begin
            // released line: no stable value for the block to read
            data_out <= ~data_out;
            di       <= 3'h0;
            si       <= 3'h0;
        end else begin
            if (chg && sclk == edge_sel) begin
                data_out <= tx_byte[msb_first ? 3'h7 - di : di];
                di       <= di + 3'h1;
            end
            if (chg && sclk != edge_sel) begin
                rx_byte <= msb_first ? {rx_byte[6:0], data_in} : {data_in, rx_byte[7:1]};
                si      <= si + 3'h1;
                if (si == 3'h7)
                    done_cnt <= done_cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* ssc_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_tb
    import ssc_pkg::*;
;
    logic        core_clk, sys_rst, reg_wr, reg_rd, pm_deep, pm_slow, sel, rd_q;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, ptx, rx_byte, done_cnt, cfg, b1, pb, irq_cnt;
    logic        sclk_o, oe_n, sdo, sdi, irq, edg, xclk;
    logic        lfc = 1'b0;
    logic [7:0]  exp_q[$];
    integer      seed, fails, n_tests;

    ssc_ctrl u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pm_deep_enter(pm_deep),
        .pm_slow(pm_slow), .low_frequency_clock(lfc), .serial_clock_pin_i(xclk),
        .serial_clock_pin_o(sclk_o), .serial_clock_pin_oe_n(oe_n), .serial_in_pin(sdi),
        .serial_out_pin(sdo), .serial_irq(irq));
    ssc_peer u_peer (
        .core_clk(core_clk), .sys_rst(sys_rst), .sclk(oe_n ? xclk : sclk_o), .data_in(sdo), .data_out(sdi),
        .edge_sel(edg), .msb_first(edg), .sel(sel), .tx_byte(ptx), .rx_byte(rx_byte),
        .done_cnt(done_cnt));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // low-frequency clock runs free; only slow modes look at it
    always #20 lfc = ~lfc;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // the expected value is queued; the watcher compares it when data stands
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge core_clk);
        reg_rd   <= 1'b0;
    endtask

    task automatic wait_done(input logic [7:0] n);
        int k;
        k = 0;
        while (done_cnt !== n && k < 3000) begin
            @(posedge core_clk);
            k = k + 1;
        end
        if (k == 3000) begin
            fails = fails + 1;
            $display("wrong value at %0t: serial byte never completed", $time);
            results();
        end
        repeat (30) @(posedge core_clk);
    endtask

    always @(posedge core_clk) begin
        if (rd_q)
            chk(reg_rdata, exp_q.pop_front());
        if (sys_rst)
            irq_cnt = 8'h00;
        else if (irq === 1'b1)
            irq_cnt = irq_cnt + 8'h01;
        rd_q <= reg_rd;
    end

    initial begin
        seed = 40782;
        fails = 0;
        n_tests = 0;
        sys_rst <= 1'b1;
        {reg_wr, reg_rd, pm_deep, pm_slow, sel, edg} <= 6'h00;
        xclk <= 1'b1;
        reg_addr <= 16'h0000;
        reg_wdata <= 8'h00;
        ptx <= 8'h00;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(OFS_STATUS, 8'h00);
        rd(16'h0055, 8'h00);
        wr(OFS_CONTROL, 8'h35);
        rd(OFS_CONTROL, 8'h00);
        wr(OFS_PWR_GATE, 8'h01);
        rd(OFS_PWR_GATE, 8'h01);
        wr(OFS_CONTROL, 8'h04);
        rd(OFS_CONTROL, 8'h00);
        rd(OFS_STATUS, 8'h00);
        for (int i = 0; i < 2; i++) begin
            edg <= i[0];
            cfg = {i[0], 3'h3, i[0], 3'b011};
            wr(OFS_CONTROL, cfg);
            b1 = $random(seed);
            pb = $random(seed);
            ptx <= pb;
            wr(OFS_DATA, b1);
            chk({7'h00, oe_n}, 8'h00);
            rd(OFS_STATUS, 8'h04);
            sel <= 1'b1;
            wr(OFS_CONTROL, cfg | 8'h04);
            rd(OFS_STATUS, 8'hc0);
            wr(OFS_CONTROL, {~i[0], 3'h1, ~i[0], 3'b110});
            rd(OFS_CONTROL, cfg | 8'h04);
            wait_done(8'(2 * i + 1));
            rd(OFS_STATUS, 8'h90);
            rd(OFS_DATA, pb);
            chk(rx_byte, b1);
            rd(OFS_STATUS, 8'h80);
            // reload, then reserved stop while the byte is still shifting
            b1 = $random(seed);
            pb = $random(seed);
            ptx <= pb;
            wr(OFS_DATA, b1);
            wr(OFS_CONTROL, cfg);
            rd(OFS_STATUS, 8'hc0);
            wait_done(8'(2 * i + 2));
            rd(OFS_STATUS, 8'h10);
            rd(OFS_DATA, pb);
            chk(rx_byte, b1);
            sel <= 1'b0;
            wr(OFS_CONTROL, {i[0], 3'h3, i[0], 3'b000});
            rd(OFS_STATUS, 8'h00);
        end
        // receive only: the second unread byte overruns
        edg <= 1'b0;
        wr(OFS_CONTROL, 8'h32);
        rd(OFS_STATUS, 8'h00);
        sel <= 1'b1;
        wr(OFS_CONTROL, 8'h36);
        wait_done(8'h06);
        rd(OFS_STATUS, 8'hf0);
        rd(OFS_STATUS, 8'hd0);
        rd(OFS_DATA, pb);
        rd(OFS_STATUS, 8'hc0);
        wr(OFS_CONTROL, 8'h70);
        sel <= 1'b0;
        // external clock with no second byte written: underrun
        wr(OFS_CONTROL, 8'h71);
        rd(OFS_STATUS, 8'h00);
        b1 = $random(seed);
        wr(OFS_DATA, b1);
        sel <= 1'b1;
        wr(OFS_CONTROL, 8'h75);
        repeat (16) begin
            repeat (8) @(posedge core_clk);
            xclk <= ~xclk;
        end
        wait_done(8'h07);
        rd(OFS_STATUS, 8'hc8);
        rd(OFS_STATUS, 8'hc0);
        chk(rx_byte, b1);
        wr(OFS_CONTROL, 8'h70);
        sel <= 1'b0;
        wr(OFS_CONTROL, 8'hd9);
        wr(OFS_CONTROL, 8'hdd);
        pm_deep <= 1'b1;
        @(posedge core_clk);
        pm_deep <= 1'b0;
        rd(OFS_CONTROL, 8'hd8);
        rd(OFS_STATUS, 8'h00);
        pm_slow <= 1'b1;
        wr(OFS_CONTROL, 8'h35);
        rd(OFS_STATUS, 8'h00);
        wr(OFS_CONTROL, 8'h65);
        rd(OFS_STATUS, 8'hc0);
        repeat (50) @(posedge core_clk);
        chk({7'h00, sclk_o}, 8'h00);
        wr(OFS_CONTROL, 8'h60);
        rd(OFS_STATUS, 8'h00);
        pm_slow <= 1'b0;
        wr(OFS_CONTROL, 8'h72);
        repeat (2) @(posedge core_clk);
        chk({7'h00, oe_n}, 8'h01);
        repeat (4) @(posedge core_clk);
        chk(irq_cnt, 8'h0a);
        chk(8'(exp_q.size()), 8'h00);
        results();
    end
endmodule
`default_nettype wire
